// [logic/rbo_map.svh]
// Register offsets, field positions, reset values and sizes of the byte ordering block.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one aligned word per register.
`ifndef RBO_MAP_SVH
`define RBO_MAP_SVH

`define RBO_ADDR_CTRL 8'h00
`define RBO_ADDR_PATTERN 8'h04
`define RBO_ADDR_PAD 8'h08
`define RBO_ADDR_STATE 8'h0C
`define RBO_ADDR_INT_STAT 8'h10
`define RBO_ADDR_INT_CLR 8'h14
`define RBO_ADDR_INT_EN 8'h18

`define RBO_CTRL_W 7
`define RBO_CTRL_RST 7'h01
`define RBO_PAT1_LSB 16
`define RBO_SYM_W 10
`define RBO_MAX_SYM 4
`define RBO_BUF_SYM 6
`define RBO_FIFO_DEPTH 4
`define RBO_INT_W 3
`define RBO_INT_ALIGNED 0
`define RBO_INT_OVERFLOW 1
`define RBO_INT_UNDERRUN 2

`endif

// [logic/rbo_pkg.sv]
// Types shared by the byte ordering and phase FIFO block.
// Assumes rbo_map.svh is on the include path.
package rbo_pkg;
	typedef enum logic [1:0] {
		RBO_SYM_8 = 2'h0,
		RBO_SYM_9 = 2'h1,
		RBO_SYM_10 = 2'h2
	} rbo_sym_type;

	typedef struct packed {
		logic reg_mode;
		logic long_pat;
		logic manual;
		rbo_sym_type sym_mode;
		logic dw;
		logic deser_en;
	} rbo_ctrl_type;

	typedef enum logic [2:0] {
		RBO_IDLE = 3'b001,
		RBO_SEARCH = 3'b010,
		RBO_LOCKED = 3'b100
	} rbo_state_type;

	typedef struct packed {
		logic aligned;
		logic [3:0] ctl;
		logic [39:0] data;
	} rbo_word_type;

	typedef struct packed {
		logic [19:0] sym;
		logic valid;
	} rbo_in_type;
endpackage

// [logic/rbo_top.sv]
// Receive byte deserializer, byte ordering and four-word phase FIFO with AHB-Lite registers.
// Assumes word aligner data, sync status and fabric strobes all arrive on hclk.
// Function
// - Single width: output twice input width
// - First received word goes to LSB
// - Ordering only with deserializer, pattern, pad
// - Insert pad until pattern sits LSByte
// - Single width pattern length 8, 9, 10
// - Top bit of 9-bit pattern is control
// - Double width pattern one or two symbols
// - 18-bit pattern is two 9-bit halves
// - Aligner and manual triggers, both widths
// - Search after sync status rising edge
// - First match pads and flags alignment in the same word
// - Later misalignment ignored until resync
// - Manual search on ordering enable edge
// - Four-word FIFO carries status and data
// - FIFO write and read share clock
// - Registered mode: one cycle latency
// - Input runs twice output word rate
`timescale 1ns/1ps
`include "rbo_map.svh"

module rbo_top #(
	parameter int DEPTH = `RBO_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Word aligner side
	input wire rbo_pkg::rbo_in_type rx_in,
	input wire logic rx_sync_status,
	// Fabric side
	input wire logic rx_order_en,
	input wire logic rx_read,
	output rbo_pkg::rbo_word_type rx_out,
	output logic rx_out_valid,
	output logic rx_byte_aligned,
	output logic irq
);
	import rbo_pkg::*;

	rbo_ctrl_type ctrl_reg;
	logic [`RBO_SYM_W-1:0] pat0_reg;
	logic [`RBO_SYM_W-1:0] pat1_reg;
	logic [`RBO_SYM_W-1:0] pad_reg;
	logic [`RBO_INT_W-1:0] int_stat_reg;
	logic [`RBO_INT_W-1:0] int_stat_next;
	logic [`RBO_INT_W-1:0] int_en_reg;
	logic [`RBO_INT_W-1:0] int_clr;
	logic [`RBO_INT_W-1:0] int_evt;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic addr_ok;
	logic addr_phase;
	logic [31:0] rd_mux;

	rbo_state_type state_reg;
	rbo_state_type state_next;
	logic sync_q_reg;
	logic ord_q_reg;
	logic trig;

	logic [`RBO_SYM_W-1:0] sb_reg [0:`RBO_BUF_SYM-1];
	logic [`RBO_SYM_W-1:0] sb_next [0:`RBO_BUF_SYM-1];
	logic [`RBO_SYM_W-1:0] t [0:`RBO_BUF_SYM-1];
	logic [`RBO_SYM_W-1:0] wsym [0:`RBO_MAX_SYM-1];
	logic [2:0] pos_reg;
	logic [2:0] pos_next;
	logic [2:0] np;
	logic [2:0] n_sym;
	logic [2:0] shift;
	logic [2:0] k;
	logic found;
	logic word_valid;
	logic align_hit;
	rbo_word_type word;

	rbo_word_type mem [0:DEPTH-1];
	logic [$clog2(DEPTH)-1:0] wp_reg;
	logic [$clog2(DEPTH)-1:0] rp_reg;
	logic [$clog2(DEPTH):0] cnt_reg;
	logic fifo_wr;
	logic fifo_rd;

	// Compare width follows symbol mode; 9-bit mode includes the control bit
	function automatic logic sym_match(input logic [`RBO_SYM_W-1:0] a,
			input logic [`RBO_SYM_W-1:0] b, input rbo_sym_type m);
		logic r;
		r = 1'b0;
		case (m)
			RBO_SYM_8: r = (a[7:0] == b[7:0]);
			RBO_SYM_9: r = (a[8:0] == b[8:0]);
			default: r = (a == b);
		endcase
		return r;
	endfunction

	// Bus address phase and register read mux
	assign addr_phase = hsel && htrans[1] && hready;
	assign addr_ok = (haddr[31:8] == 24'h00_0000);

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (!addr_ok) begin
			rd_mux = 32'h0000_0000;
		end else if (haddr[7:0] == `RBO_ADDR_CTRL) begin
			rd_mux = {25'h000_0000, ctrl_reg};
		end else if (haddr[7:0] == `RBO_ADDR_PATTERN) begin
			rd_mux = {6'h00, pat1_reg, 6'h00, pat0_reg};
		end else if (haddr[7:0] == `RBO_ADDR_PAD) begin
			rd_mux = {22'h00_0000, pad_reg};
		end else if (haddr[7:0] == `RBO_ADDR_STATE) begin
			rd_mux = {21'h00_0000, cnt_reg[2:0], pos_reg, 2'h0, state_reg};
		end else if (haddr[7:0] == `RBO_ADDR_INT_STAT) begin
			rd_mux = {29'h0000_0000, int_stat_reg};
		end else if (haddr[7:0] == `RBO_ADDR_INT_EN) begin
			rd_mux = {29'h0000_0000, int_en_reg};
		end
	end

	// Zero wait state slave; read data is registered at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= addr_phase && hwrite && addr_ok;
			wr_addr_reg <= haddr[7:0];
			if (addr_phase && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Software writes steer the ordering logic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= rbo_ctrl_type'(`RBO_CTRL_RST);
			pat0_reg <= 10'h000;
			pat1_reg <= 10'h000;
			pad_reg <= 10'h000;
			int_en_reg <= 3'h0;
		end else if (wr_pend_reg) begin
			if (wr_addr_reg == `RBO_ADDR_CTRL) begin
				ctrl_reg <= rbo_ctrl_type'(hwdata[`RBO_CTRL_W-1:0]);
			end else if (wr_addr_reg == `RBO_ADDR_PATTERN) begin
				pat0_reg <= hwdata[`RBO_SYM_W-1:0];
				pat1_reg <= hwdata[`RBO_PAT1_LSB +: `RBO_SYM_W];
			end else if (wr_addr_reg == `RBO_ADDR_PAD) begin
				pad_reg <= hwdata[`RBO_SYM_W-1:0];
			end else if (wr_addr_reg == `RBO_ADDR_INT_EN) begin
				int_en_reg <= hwdata[`RBO_INT_W-1:0];
			end
		end
	end

	assign int_clr = (wr_pend_reg && wr_addr_reg == `RBO_ADDR_INT_CLR) ?
		hwdata[`RBO_INT_W-1:0] : 3'h0;
	// A new event wins over a clear in the same cycle
	assign int_stat_next = (int_stat_reg & ~int_clr) | int_evt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_stat_reg <= 3'h0;
			irq <= 1'b0;
		end else begin
			int_stat_reg <= int_stat_next;
			irq <= |(int_stat_next & int_en_reg);
		end
	end

	// Trigger edges; ordering only runs with the deserializer on
	assign trig = ctrl_reg.deser_en && (ctrl_reg.manual ?
		(rx_order_en && !ord_q_reg) :
		(rx_sync_status && !sync_q_reg));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_q_reg <= 1'b0;
			ord_q_reg <= 1'b0;
		end else begin
			sync_q_reg <= rx_sync_status;
			ord_q_reg <= rx_order_en;
		end
	end

	// Deserializer assembly, pattern search and pad insertion
	always_comb begin
		n_sym = ctrl_reg.dw ? 3'h4 : 3'h2;
		np = pos_reg + (ctrl_reg.dw ? 3'h2 : 3'h1);
		for (int i = 0; i < `RBO_BUF_SYM; i++) begin
			t[i] = sb_reg[i];
		end
		// Earlier symbols sit at lower positions of the widened word
		t[pos_reg] = rx_in.sym[9:0];
		if (ctrl_reg.dw) begin
			t[3'(pos_reg + 3'h1)] = rx_in.sym[19:10];
		end
		found = 1'b0;
		k = 3'h0;
		for (int i = `RBO_MAX_SYM - 1; i >= 0; i--) begin
			if (3'(i) < n_sym && sym_match(t[i], pat0_reg, ctrl_reg.sym_mode) &&
					(!(ctrl_reg.long_pat && ctrl_reg.dw) ||
					(3'(i + 1) < n_sym && sym_match(t[i + 1], pat1_reg, ctrl_reg.sym_mode)))) begin
				found = 1'b1;
				k = 3'(i);
			end
		end
		word_valid = 1'b0;
		align_hit = 1'b0;
		shift = n_sym;
		pos_next = pos_reg;
		for (int i = 0; i < `RBO_BUF_SYM; i++) begin
			sb_next[i] = sb_reg[i];
		end
		if (rx_in.valid && ctrl_reg.deser_en) begin
			pos_next = np;
			for (int i = 0; i < `RBO_BUF_SYM; i++) begin
				sb_next[i] = t[i];
			end
			if (np >= n_sym) begin
				word_valid = 1'b1;
				if (state_reg == RBO_SEARCH && found) begin
					align_hit = 1'b1;
					shift = (k == 3'h0) ? n_sym : k;
				end
				pos_next = np - shift;
				for (int i = 0; i < `RBO_BUF_SYM; i++) begin
					sb_next[i] = (i + int'(shift) < `RBO_BUF_SYM) ? t[i + int'(shift)] : 10'h000;
				end
			end
		end else if (!ctrl_reg.deser_en) begin
			word_valid = rx_in.valid;
			pos_next = 3'h0;
		end
		for (int i = 0; i < `RBO_MAX_SYM; i++) begin
			if (!ctrl_reg.deser_en) begin
				wsym[i] = (i < 2) ? rx_in.sym[i*10 +: 10] : 10'h000;
			end else if (3'(i) >= n_sym) begin
				wsym[i] = 10'h000;
			end else begin
				wsym[i] = (3'(i) < shift) ? t[i] : pad_reg;
			end
		end
		// Dense packing at 8 or 10 bits per symbol; 9-bit mode packs 8 bits and puts bit 8 in ctl
		word = '0;
		word.aligned = (state_reg == RBO_LOCKED) || align_hit;
		for (int i = 0; i < `RBO_MAX_SYM; i++) begin
			case (ctrl_reg.sym_mode)
				RBO_SYM_8: word.data[i*8 +: 8] = wsym[i][7:0];
				RBO_SYM_9: begin
					word.data[i*8 +: 8] = wsym[i][7:0];
					word.ctl[i] = wsym[i][8];
				end
				default: word.data[i*10 +: 10] = wsym[i];
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_reg <= 3'h0;
			for (int i = 0; i < `RBO_BUF_SYM; i++) begin
				sb_reg[i] <= 10'h000;
			end
		end else begin
			pos_reg <= pos_next;
			for (int i = 0; i < `RBO_BUF_SYM; i++) begin
				sb_reg[i] <= sb_next[i];
			end
		end
	end

	// Ordering state; a trigger restarts the search even when locked
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RBO_IDLE: if (trig) state_next = RBO_SEARCH;
			RBO_SEARCH: if (align_hit) state_next = RBO_LOCKED;
			RBO_LOCKED: if (trig) state_next = RBO_SEARCH;
			default: state_next = RBO_IDLE;
		endcase
		if (!ctrl_reg.deser_en) begin
			state_next = RBO_IDLE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= RBO_IDLE;
			rx_byte_aligned <= 1'b0;
		end else begin
			state_reg <= state_next;
			rx_byte_aligned <= (state_next == RBO_LOCKED);
		end
	end

	// Phase FIFO; one clock here, so both sides run at 0 ppm by construction
	// A read in the same cycle frees a slot, so a full FIFO still takes the word
	assign fifo_wr = word_valid && !ctrl_reg.reg_mode &&
		(cnt_reg < ($clog2(DEPTH)+1)'(DEPTH) || fifo_rd);
	assign fifo_rd = rx_read && !ctrl_reg.reg_mode && (cnt_reg != '0);
	assign int_evt[`RBO_INT_ALIGNED] = align_hit;
	assign int_evt[`RBO_INT_OVERFLOW] = word_valid && !ctrl_reg.reg_mode && !fifo_wr;
	assign int_evt[`RBO_INT_UNDERRUN] = rx_read && !ctrl_reg.reg_mode && (cnt_reg == '0);

	always_ff @(posedge hclk) begin
		if (fifo_wr) begin
			mem[wp_reg] <= word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else if (ctrl_reg.reg_mode) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= fifo_wr ? wp_reg + 1'b1 : wp_reg;
			rp_reg <= fifo_rd ? rp_reg + 1'b1 : rp_reg;
			cnt_reg <= cnt_reg + {{$clog2(DEPTH){1'b0}}, fifo_wr} -
				{{$clog2(DEPTH){1'b0}}, fifo_rd};
		end
	end

	// Registered mode skips the FIFO for a fixed single cycle of latency
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_out <= '0;
			rx_out_valid <= 1'b0;
		end else if (ctrl_reg.reg_mode) begin
			rx_out_valid <= word_valid;
			if (word_valid) begin
				rx_out <= word;
			end
		end else begin
			rx_out_valid <= fifo_rd;
			if (fifo_rd) begin
				rx_out <= mem[rp_reg];
			end
		end
	end
endmodule

// [sim/rbo_checker.sv]
// Port assertions for the byte ordering block.
// Assumes the single hclk domain; attached to rbo_top by bind.
`timescale 1ns/1ps
module rbo_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Stream
	input wire rbo_pkg::rbo_in_type rx_in,
	input wire logic rx_sync_status,
	input wire logic rx_order_en,
	input wire logic rx_read,
	input wire rbo_pkg::rbo_word_type rx_out,
	input wire logic rx_out_valid,
	input wire logic rx_byte_aligned,
	input wire logic irq
);
	import rbo_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// The first edge out of reset still shows the reset value of hreadyout
	a_ready_high: assert property (hresetn |=> hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (hresp == 1'h0)
		else $error("hresp not okay");
	a_rdata_hold: assert property (!$past(hsel && htrans[1] && !hwrite) |-> $stable(hrdata))
		else $error("hrdata moved");
	a_out_cause: assert property (rx_out_valid |-> $past(rx_in.valid) || $past(rx_read))
		else $error("word without cause");
	a_out_hold: assert property (!rx_out_valid |-> $stable(rx_out))
		else $error("word moved");
	a_align_cause: assert property ($rose(rx_byte_aligned) |-> $past(rx_in.valid))
		else $error("alignment without input");
	// A write may reconfigure the block, so it may also drop alignment
	a_align_drop: assert property ($fell(rx_byte_aligned) |->
		$past(rx_sync_status) || $past(rx_order_en) || $past(hwrite) || $past(hwrite, 2))
		else $error("alignment lost");
	a_irq_drop: assert property ($fell(irq) |-> $past(hwrite) || $past(hwrite, 2))
		else $error("irq fell");
	c_aligned: cover property ($rose(rx_byte_aligned));
	c_fifo_read: cover property (rx_read && rx_out_valid);
	c_irq: cover property ($rose(irq));
endmodule

bind rbo_top rbo_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_in),
	.rx_sync_status(rx_sync_status), .rx_order_en(rx_order_en), .rx_read(rx_read),
	.rx_out(rx_out), .rx_out_valid(rx_out_valid), .rx_byte_aligned(rx_byte_aligned), .irq(irq));

// [sim/rbo_fabric_model.sv]
// Fabric logic beside the block: read strobes and the manual ordering enable.
// Assumes it shares hclk and hresetn with the block.
`timescale 1ns/1ps
module rbo_fabric_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bench control
	input wire logic go,
	input wire logic slow,
	input wire logic trig,
	// Fabric strobes
	output logic rx_read,
	output logic rx_order_en
);
	logic [1:0] gap_reg;
	// Slow reading lets the FIFO back up; prompt reading runs it dry
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_reg <= 2'h0;
			rx_read <= 1'h0;
		end else begin
			gap_reg <= gap_reg + 2'h1;
			rx_read <= go && (!slow || gap_reg == 2'h3);
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_order_en <= 1'h0;
		end else begin
			rx_order_en <= trig;
		end
	end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the byte ordering block, registers over AHB-Lite.
// Assumes rbo_map.svh on the include path and the fabric model beside the block.
`timescale 1ns/1ps
`include "rbo_map.svh"
module tb_top;
	import rbo_pkg::*;
	logic hclk, hresetn, hready, hresp, rx_order_en, rx_read, rx_out_valid, rx_byte_aligned, irq;
	logic hsel = 1'h1, hwrite = 1'h0, rx_sync_status = 1'h0, go = 1'h0, slow = 1'h0, trig = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	rbo_in_type rx_in = '0;
	rbo_word_type rx_out, w;
	rbo_word_type q[$];
	int n_errors = 0, cmp_count = 0;
	rbo_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .rx_in(rx_in), .rx_sync_status(rx_sync_status),
		.rx_order_en(rx_order_en), .rx_read(rx_read), .rx_out(rx_out),
		.rx_out_valid(rx_out_valid), .rx_byte_aligned(rx_byte_aligned), .irq(irq));
	rbo_fabric_model PEER (.hclk(hclk), .hresetn(hresetn), .go(go), .slow(slow), .trig(trig),
		.rx_read(rx_read), .rx_order_en(rx_order_en));
	initial begin
		hclk = 1'h0;
		forever #20 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (rx_out_valid === 1'h1) begin
			q.push_back(rx_out);
		end
	end
	task automatic tally_and_finish();
		$display("compares %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic ck(input logic [43:0] g, input logic [43:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic lim(input int k);
		if (k >= 60) begin
			n_errors++;
			$display("unexpected at %0t: wait ran out", $time);
			tally_and_finish();
		end
	endtask
	task automatic wrdy();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hready !== 1'h1 && k < 60);
		lim(k);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wrdy();
		htrans <= 2'h0;
		hwdata <= d;
		wrdy();
		rd = hrdata;
	endtask
	task automatic sym(input logic [19:0] s);
		@(posedge hclk);
		rx_in <= '{sym: s, valid: 1'h1};
		@(posedge hclk);
		rx_in.valid <= 1'h0;
	endtask
	task automatic pop();
		int k;
		k = 0;
		while (q.size() == 0 && k < 60) begin
			@(posedge hclk);
			k++;
		end
		lim(k);
		w = q.pop_front();
	endtask
	task automatic t_regs();
		bus(1'h0, `RBO_ADDR_CTRL, 32'h0);
		ck(rd, 32'h01);
		bus(1'h1, 8'h40, 32'hFFFF_FFFF);
		bus(1'h0, 8'h40, 32'h0);
		ck(rd, 32'h0);
		$display("test regs done");
	endtask
	// Trigger a search, send three input words, expect padded word then aligned word
	task automatic t_order(input logic [31:0] c, p, d, input logic [19:0] w0, w1, w2,
		input logic [43:0] e1, e2, input logic man);
		bus(1'h1, `RBO_ADDR_CTRL, c);
		bus(1'h1, `RBO_ADDR_PATTERN, p);
		bus(1'h1, `RBO_ADDR_PAD, d);
		rx_sync_status <= 1'h0;
		trig <= 1'h0;
		@(posedge hclk);
		rx_sync_status <= !man;
		trig <= man;
		repeat (2) @(posedge hclk);
		q.delete();
		sym(w0);
		ck(rx_byte_aligned, 1'h0);
		sym(w1);
		// Registered mode: the word stands just after the edge that took its last symbol
		#1;
		ck(rx_out_valid, 1'h1);
		sym(w2);
		pop();
		ck({w.ctl, w.data}, e1);
		ck(w.aligned, 1'h1);
		pop();
		ck(w.data, e2);
		ck(rx_byte_aligned, 1'h1);
		$display("test order %h done", c);
	endtask
	// Pattern off the low lane after lock: manual mode first, then aligner mode
	task automatic t_ignore();
		rx_sync_status <= 1'h1;
		for (int m = 0; m < 2; m++) begin
			if (m == 1) begin
				bus(1'h1, `RBO_ADDR_CTRL, 32'h41);
			end
			sym(20'h11);
			sym(20'hBC);
			pop();
			ck(w.data, 44'hBC11);
			ck(rx_byte_aligned, 1'h1);
		end
		$display("test ignore done");
	endtask
	task automatic t_off();
		bus(1'h1, `RBO_ADDR_CTRL, 32'h40);
		rx_sync_status <= 1'h0;
		@(posedge hclk);
		rx_sync_status <= 1'h1;
		sym(20'hBC);
		sym(20'h11);
		bus(1'h0, `RBO_ADDR_STATE, 32'h0);
		ck(rd[2:0], 3'h1);
		ck(rx_byte_aligned, 1'h0);
		$display("test off done");
	endtask
	task automatic t_fifo();
		bus(1'h1, `RBO_ADDR_CTRL, 32'h01);
		bus(1'h1, `RBO_ADDR_INT_CLR, 32'h7);
		q.delete();
		for (int i = 1; i <= 10; i++) begin
			sym(20'(i));
		end
		bus(1'h0, `RBO_ADDR_STATE, 32'h0);
		ck(rd[10:8], 3'h4);
		bus(1'h0, `RBO_ADDR_INT_STAT, 32'h0);
		ck(rd[1], 1'h1);
		slow <= 1'h1;
		go <= 1'h1;
		for (int i = 1; i < 8; i += 2) begin
			pop();
			ck(w.data, 44'({i[7:0] + 8'h1, i[7:0]}));
		end
		slow <= 1'h0;
		repeat (12) @(posedge hclk);
		go <= 1'h0;
		ck(q.size(), 44'h0);
		bus(1'h0, `RBO_ADDR_INT_STAT, 32'h0);
		ck(rd[2:1], 2'h3);
		bus(1'h1, `RBO_ADDR_INT_EN, 32'h1);
		repeat (2) @(posedge hclk);
		ck(irq, 1'h0);
		bus(1'h1, `RBO_ADDR_INT_EN, 32'h4);
		repeat (2) @(posedge hclk);
		ck(irq, 1'h1);
		bus(1'h1, `RBO_ADDR_INT_CLR, 32'h6);
		repeat (2) @(posedge hclk);
		ck(irq, 1'h0);
		$display("test fifo done");
	endtask
	initial begin
		hresetn <= 1'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		repeat (2) @(posedge hclk);
		t_regs();
		t_order(32'h41, 32'hBC, 32'h55, 20'h11, 20'hBC, 20'h22,
			44'h5511, 44'h22BC, 1'h0);
		t_order(32'h45, 32'h1BC, 32'h155, 20'h0BC, 20'h1BC, 20'h022,
			44'h200_0000_55BC, 44'h22BC, 1'h0);
		t_order(32'h49, 32'h3FA, 32'h2AA, 20'h111, 20'h3FA, 20'h0F0,
			44'hA_A911, 44'h3_C3FA, 1'h0);
		t_order(32'h63, 32'h3C_00BC, 32'h55, 20'h2_A8BB, 20'hF0BC, 20'h8811,
			44'h5555_AABB, 44'h2211_3CBC, 1'h0);
		t_order(32'h67, 32'h3C_01BC, 32'h155, 20'h2_A8BB, 20'hF1BC, 20'h8811,
			44'hC00_5555_AABB, 44'h2211_3CBC, 1'h0);
		t_order(32'h51, 32'hBC, 32'h55, 20'h11, 20'hBC, 20'h22,
			44'h5511, 44'h22BC, 1'h1);
		t_ignore();
		t_off();
		t_fifo();
		tally_and_finish();
	end
endmodule
